// File: logic/mpc_pkg.sv
// constants and types for the module power-on control block
package mpc_pkg;

  // ==========================================================
  // timing
  localparam int unsigned MPC_CLK_HZ          = 100_000_000;
  localparam int unsigned MPC_PULSE_MIN_US    = 1000;
  localparam int unsigned MPC_PULSE_MIN_CYC   =
    (MPC_PULSE_MIN_US * (MPC_CLK_HZ / 1_000_000));
  localparam int unsigned MPC_RESET_LOW_MS    = 50;
  localparam int unsigned MPC_RESET_LOW_CYC   =
    MPC_RESET_LOW_MS * (MPC_CLK_HZ / 1000);
  localparam int unsigned MPC_CNT_W           = 24;

  // ==========================================================
  // values after reset
  localparam logic        MPC_SYNC_RESET_VAL  = 1'b1;

  // ==========================================================
  // power states
  typedef enum logic [1:0] {
    MPC_NOT_POWERED = 2'b00,
    MPC_OFF         = 2'b01,
    MPC_ON          = 2'b10,
    MPC_SUPPLY_HOLD = 2'b11
  } mpc_state_type;

endpackage

// File: logic/mpc_sync.sv
// two-stage synchroniser for one pin input
`timescale 1ns/1ps
module mpc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // data
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// File: logic/mpc_top.sv
// power-state and wake-up control of the module
// How it works
// - the interface supply is on only in the on state with reset released.
// - from not powered, a supply rise from below 2.25 V switches on.
// - a reset held low over the supply rise switches on at its release.
// - the power-on pin is ignored while the supply is being applied.
// - power-off command enters off; only pin pulse, reset or alarm wake it.
// - in off, a low pulse of the minimum length on power-on starts up.
// - in off, a rising edge on the reset pin starts up.
// - in off, the alarm reaching its programmed time starts up.
`timescale 1ns/1ps
module mpc_top
  import mpc_pkg::*;
#(
  parameter int unsigned PULSE_MIN_CYC = mpc_pkg::MPC_PULSE_MIN_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // supply supervision
  input  wire logic supply_valid,
  input  wire logic supply_was_low,
  // host pins
  input  wire logic power_on_request_pin_n,
  input  wire logic hw_reset_pin_n,
  // internal events
  input  wire logic software_power_off_cmd,
  input  wire logic alarm_due,
  // status outputs
  output logic      interface_supply_en,
  output mpc_pkg::mpc_state_type power_state,
  output logic      wake_event
);

  import mpc_pkg::*;

  // ==========================================================
  // synchronisers
  logic pwr_s;
  logic rst_s;
  logic sup_s;
  logic low_s;

  mpc_sync #(.RESET_VAL(MPC_SYNC_RESET_VAL)) u_sync_pwr (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (power_on_request_pin_n),
    .sync_out (pwr_s)
  );
  mpc_sync #(.RESET_VAL(MPC_SYNC_RESET_VAL)) u_sync_rst (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (hw_reset_pin_n),
    .sync_out (rst_s)
  );
  mpc_sync #(.RESET_VAL(1'b0)) u_sync_sup (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (supply_valid),
    .sync_out (sup_s)
  );
  mpc_sync #(.RESET_VAL(1'b1)) u_sync_low (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (supply_was_low),
    .sync_out (low_s)
  );

  // ==========================================================
  // pin edge history
  logic                    rst_prev_q;
  logic                    rst_prev_d;
  logic                    pwr_prev_q;
  logic                    pwr_prev_d;
  logic                    pwr_fall;
  logic                    rst_rise;

  // edge of a synchronised pin; history resets to the idle high level
  function automatic logic pin_fell(input logic prev, input logic now);
    return prev && !now;
  endfunction

  function automatic logic pin_rose(input logic prev, input logic now);
    return !prev && now;
  endfunction

  // edges taken from synchronised copies only
  always_comb begin
    rst_prev_d = rst_s;
    pwr_prev_d = pwr_s;
    pwr_fall   = pin_fell(pwr_prev_q, pwr_s);
    rst_rise   = pin_rose(rst_prev_q, rst_s);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_prev_q <= MPC_SYNC_RESET_VAL;
      pwr_prev_q <= MPC_SYNC_RESET_VAL;
    end else begin
      rst_prev_q <= rst_prev_d;
      pwr_prev_q <= pwr_prev_d;
    end
  end

  // ==========================================================
  // power-on low-pulse timer
  localparam logic [MPC_CNT_W-1:0] CNT_MAX = MPC_CNT_W'(PULSE_MIN_CYC);

  logic                    armed_q;
  logic                    armed_d;
  logic [MPC_CNT_W-1:0]    cnt_q;
  logic [MPC_CNT_W-1:0]    cnt_d;
  logic                    pulse_done;

  // runs only in off; an early release disarms it
  always_comb begin
    armed_d = armed_q;
    cnt_d   = cnt_q;
    if (!sup_s || (state_q != MPC_OFF)) begin
      armed_d = 1'b0;
      cnt_d   = '0;
    end else if (pwr_fall) begin
      armed_d = 1'b1;
      cnt_d   = '0;
    end else if (armed_q && pwr_s) begin
      armed_d = 1'b0;
    end else if (armed_q && (cnt_q != CNT_MAX)) begin
      cnt_d = cnt_q + 1'b1;
    end
    pulse_done = armed_q && !pwr_s && (cnt_q == CNT_MAX);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      armed_q <= 1'b0;
      cnt_q   <= '0;
    end else begin
      armed_q <= armed_d;
      cnt_q   <= cnt_d;
    end
  end

  // ==========================================================
  // power state
  mpc_state_type           state_q;
  mpc_state_type           state_d;
  logic                    wake_q;
  logic                    wake_d;

  always_comb begin
    state_d = state_q;
    wake_d  = 1'b0;
    if (!sup_s) begin
      // supply loss wins over every other event
      state_d = MPC_NOT_POWERED;
    end else begin
      case (state_q)
        MPC_NOT_POWERED: begin
          // power-on pin is not looked at here
          if (!rst_s) begin
            state_d = MPC_SUPPLY_HOLD;
          end else if (low_s) begin
            state_d = MPC_ON;
          end
        end
        MPC_SUPPLY_HOLD: begin
          if (rst_s) begin
            state_d = MPC_ON;
          end
        end
        MPC_ON: begin
          if (software_power_off_cmd) begin
            state_d = MPC_OFF;
          end
        end
        MPC_OFF: begin
          // apart from supply loss above, only the three wake events leave off
          if (pulse_done
              || rst_rise
              || alarm_due) begin
            state_d = MPC_ON;
            wake_d  = 1'b1;
          end
        end
        default: begin
          state_d = MPC_NOT_POWERED;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= MPC_NOT_POWERED;
      wake_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      wake_q  <= wake_d;
    end
  end

  // ==========================================================
  // interface supply enable
  logic                    en_q;
  logic                    en_d;

  // from the next state so it moves on the same edge as the state
  always_comb begin
    en_d = (state_d == MPC_ON) && rst_s;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en_d;
    end
  end

  // ==========================================================
  // outputs
  assign interface_supply_en = en_q;
  assign power_state         = state_q;
  assign wake_event          = wake_q;

endmodule

// File: verif/mpc_checker.sv
// port assertions for the power-on control block
`timescale 1ns/1ps
module mpc_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // inputs
  input wire logic supply_valid,
  input wire logic supply_was_low,
  input wire logic power_on_request_pin_n,
  input wire logic hw_reset_pin_n,
  input wire logic software_power_off_cmd,
  input wire logic alarm_due,
  // outputs
  input wire logic interface_supply_en,
  input wire mpc_pkg::mpc_state_type power_state,
  input wire logic wake_event
);
  import mpc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // assertions
  chk_en_on_only: assert property (
    interface_supply_en |-> power_state == MPC_ON) else $error("en not on");
  chk_en_rst_low: assert property (
    !hw_reset_pin_n [*4] |-> !interface_supply_en) else $error("en in rst");
  chk_off_cmd: assert property (
    supply_valid [*3] ##0 (power_state == MPC_ON && software_power_off_cmd)
    |=> power_state == MPC_OFF) else $error("no off");
  chk_alarm_wake: assert property (
    supply_valid [*3] ##0 (power_state == MPC_OFF && alarm_due)
    |=> power_state == MPC_ON) else $error("no alarm wake");
  chk_wake_pulse: assert property (
    wake_event |=> !wake_event) else $error("wake too long");
  chk_wake_from_off: assert property (
    wake_event |-> power_state == MPC_ON && $past(power_state) == MPC_OFF)
    else $error("bad wake");
  chk_no_power: assert property (
    !supply_valid [*4] |-> power_state == MPC_NOT_POWERED)
    else $error("powered w/o supply");
  chk_rst_wake: assert property (
    !hw_reset_pin_n [*3] ##1 (hw_reset_pin_n && power_state == MPC_OFF)
    |=> power_state == MPC_OFF ##[1:3] power_state == MPC_ON)
    else $error("rst wake");
  cover property (wake_event);
  cover property (power_state == MPC_SUPPLY_HOLD);
  cover property ($fell(interface_supply_en));
endmodule

// File: verif/mpc_host.sv
// host model driving the power-on and reset pins
`timescale 1ns/1ps
module mpc_host #(
  parameter int LOW_CYC = 20
) (
  input  wire logic clk,
  output logic      power_on_request_pin_n,
  output logic      hw_reset_pin_n
);
  initial power_on_request_pin_n = 1'b1;
  initial hw_reset_pin_n = 1'b1;
  task automatic drive(input logic p, input logic r);
    @(posedge clk) #1 power_on_request_pin_n = p;
    hw_reset_pin_n = r;
  endtask
  task automatic press(input int n);
    drive(1'b0, 1'b1);
    repeat (n) @(posedge clk);
    #1 power_on_request_pin_n = 1'b1;
  endtask
  // low time scaled down to keep the run short
  task automatic rst_wake;
    drive(1'b1, 1'b0);
    repeat (LOW_CYC) @(posedge clk);
    #1 hw_reset_pin_n = 1'b1;
  endtask
endmodule

// File: verif/module_power_on_control_bench.sv
// bench for the power-on control block
`timescale 1ns/1ps
module module_power_on_control_bench;
  import mpc_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, supply_valid = 1'b0;
  logic supply_was_low = 1'b1, software_power_off_cmd = 1'b0;
  logic alarm_due = 1'b0, power_on_request_pin_n, hw_reset_pin_n;
  logic interface_supply_en, wake_event;
  mpc_state_type power_state;
  int errors = 0, tests_run = 0, cyc = 0;
  logic [1:0] wakes = 2'h0;
  mpc_top #(.PULSE_MIN_CYC(10)) i_dut (.clk, .reset_n, .supply_valid,
    .supply_was_low, .power_on_request_pin_n, .hw_reset_pin_n,
    .software_power_off_cmd, .alarm_due, .interface_supply_en,
    .power_state, .wake_event);
  mpc_host i_host (.clk, .power_on_request_pin_n, .hw_reset_pin_n);
  initial forever #5 clk = ~clk;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic pulse_cmd(input logic c, input logic a);
    software_power_off_cmd = c;
    alarm_due = a;
    step(1);
    software_power_off_cmd = 1'b0;
    alarm_due = 1'b0;
    step(1);
  endtask
  task automatic t_supply;
    i_host.drive(1'b0, 1'b1);
    supply_valid = 1'b1;
    step(6);
    check(power_state, MPC_ON);
    check({1'b0, interface_supply_en}, 2'h1);
    check(wakes, 2'h0);
    i_host.drive(1'b1, 1'b1);
  endtask
  task automatic t_off_press;
    pulse_cmd(1'b1, 1'b0);
    check(power_state, MPC_OFF);
    check({1'b0, interface_supply_en}, 2'h0);
    pulse_cmd(1'b1, 1'b0);
    i_host.press(3);
    step(4);
    check(power_state, MPC_OFF);
    check(wakes, 2'h0);
    i_host.press(20);
    step(4);
    check(power_state, MPC_ON);
    check(wakes, 2'h1);
  endtask
  task automatic t_rst_alarm;
    pulse_cmd(1'b1, 1'b0);
    i_host.rst_wake;
    step(5);
    check(power_state, MPC_ON);
    check(wakes, 2'h2);
    pulse_cmd(1'b1, 1'b0);
    pulse_cmd(1'b0, 1'b1);
    check(power_state, MPC_ON);
    check(wakes, 2'h3);
  endtask
  // reset pin low while on drops the enable only
  task automatic t_rst_on;
    i_host.drive(1'b1, 1'b0);
    step(5);
    check({1'b0, interface_supply_en}, 2'h0);
    check(power_state, MPC_ON);
    i_host.drive(1'b1, 1'b1);
    step(5);
    check({1'b0, interface_supply_en}, 2'h1);
    check(wakes, 2'h3);
  endtask
  task automatic t_hold;
    supply_valid = 1'b0;
    supply_was_low = 1'b0;
    step(5);
    supply_valid = 1'b1;
    step(6);
    check(power_state, MPC_NOT_POWERED);
    supply_valid = 1'b0;
    supply_was_low = 1'b1;
    i_host.drive(1'b1, 1'b0);
    step(5);
    supply_valid = 1'b1;
    step(6);
    check(power_state, MPC_SUPPLY_HOLD);
    check({1'b0, interface_supply_en}, 2'h0);
    i_host.drive(1'b1, 1'b1);
    step(6);
    check(power_state, MPC_ON);
    check(wakes, 2'h3);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wake_event === 1'b1) begin
      wakes <= wakes + 2'h1;
    end
    if (cyc == 3000) begin
      errors++;
      stop_test;
    end
  end
  initial begin
    step(8);
    reset_n = 1'b1;
    t_supply;
    t_off_press;
    t_rst_alarm;
    t_rst_on;
    t_hold;
    stop_test;
  end
endmodule
bind mpc_top mpc_checker i_chk (.clk, .reset_n, .supply_valid,
  .supply_was_low, .power_on_request_pin_n, .hw_reset_pin_n,
  .software_power_off_cmd, .alarm_due, .interface_supply_en,
  .power_state, .wake_event);
